// ### aswc_chk.sv
// Purpose: port-level assertions for the converter status block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   attached by bind from the bench top file
`timescale 1ns/1ps
module aswc_chk (
   // clock and reset
   input wire logic                        CLK_IN,
   input wire logic                        SRST_IN,
   // register port
   input wire logic                        REG_WR_IN,
   input wire logic                        REG_RD_IN,
   input wire logic [aswc_pkg::DATA_W-1:0] REG_RDATA_OUT,
   // converter events and results
   input wire logic                        CONV_START_IN,
   input wire logic                        CONV_DONE_IN,
   input wire logic                        SCAN_MODE_IN,
   input wire logic                        IRQ_OUT,
   input wire logic                        SCAN_ABORT_OUT,
   input wire logic                        SEQ_BUSY_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (SRST_IN);
   // abort is a lone pulse
   sequence abort_pulse;
      SCAN_ABORT_OUT ##1 !SCAN_ABORT_OUT;
   endsequence
   // a hit needs two edges from the finished conversion to the abort
   sequence hit_two_back;
      $past(CONV_DONE_IN, 2) && $past(SCAN_MODE_IN);
   endsequence
   // read data stand only in the cycle after the strobe
   a_rdata_idle_zero: assert property (!$past(REG_RD_IN) |->
      REG_RDATA_OUT == '0) else $error("read data outside read slot");
   a_rsvd_read_zero: assert property ($past(REG_RD_IN) |->
      REG_RDATA_OUT[31:8] == '0) else $error("reserved bits not zero");
   a_abort_one_cycle: assert property (
      SCAN_ABORT_OUT |-> abort_pulse) else $error("abort too long");
   a_abort_has_cause: assert property (
      SCAN_ABORT_OUT |-> hit_two_back) else $error("abort without hit");
   a_abort_ends_run: assert property (
      SCAN_ABORT_OUT |-> $past(SEQ_BUSY_OUT) && !SEQ_BUSY_OUT)
      else $error("abort outside a running scan");
   a_irq_rise_cause: assert property ($rose(IRQ_OUT) |->
      $past(CONV_START_IN, 2) || $past(CONV_DONE_IN, 2) ||
      $past(CONV_DONE_IN, 3) || $past(REG_WR_IN, 2))
      else $error("interrupt rose without event");
   a_irq_fall_write: assert property (
      $fell(IRQ_OUT) |-> $past(REG_WR_IN, 2))
      else $error("interrupt fell without write");
   a_busy_rise_start: assert property ($rose(SEQ_BUSY_OUT) |->
      $past(CONV_START_IN) || $past(CONV_START_IN, 2))
      else $error("busy without start");
   a_busy_end_done: assert property ($fell(SEQ_BUSY_OUT) |->
      $past(CONV_DONE_IN) || $past(CONV_DONE_IN, 2) ||
      $past(CONV_DONE_IN, 3)) else $error("busy ended without done");
endmodule // aswc_chk

// ### aswc_cmp_if.sv
// Purpose: carrier between the control logic and the window comparator
// Assumes: both ends on the same clock
// Notes:   hit is a registered one-cycle pulse

`timescale 1ns/1ps

interface aswc_cmp_if;
   logic                                sample_valid;
   logic [aswc_pkg::CHAN_W-1:0]         sample_chan;
   logic [aswc_pkg::RESULT_W-1:0]       sample_value;
   logic [aswc_pkg::RESULT_W-1:0]       upper;
   logic [aswc_pkg::RESULT_W-1:0]       lower;
   logic                                regular_en;
   logic                                single_en;
   logic [aswc_pkg::CHAN_W-1:0]         chan_sel;
   logic                                hit;

   modport ctrl (
      output sample_valid, sample_chan, sample_value, upper, lower,
      output regular_en, single_en, chan_sel,
      input  hit
   );
   modport cmp (
      input  sample_valid, sample_chan, sample_value, upper, lower,
      input  regular_en, single_en, chan_sel,
      output hit
   );
endinterface // aswc_cmp_if

// ### aswc_pkg.sv
// Purpose: shared constants and types of the converter status/watchdog block
// Assumes: 32-bit register port, 12-bit results, channels 0 to 9
// Notes:   every offset, bit position and reset value lives here

package aswc_pkg;

   // widths
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned RESULT_W = 12;
   localparam int unsigned CHAN_W   = 4;
   localparam int unsigned STS_W    = 4;
   localparam int unsigned CTRL_W   = 8;

   // register byte offsets
   localparam logic [ADDR_W-1:0] STS_OFFSET  = 8'h00;
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;
   localparam logic [ADDR_W-1:0] MASK_OFFSET = 8'h40;

   // converter_status_flags bit positions
   localparam int unsigned STS_WDOG_BIT  = 0;
   localparam int unsigned STS_GROUP_BIT = 1;
   localparam int unsigned STS_START_BIT = 2;
   localparam int unsigned STS_ANY_BIT   = 3;

   // converter_watchdog_irq_control bit positions
   localparam int unsigned CTRL_CHSEL_LSB   = 0;
   localparam int unsigned CTRL_GROUP_IEN   = 4;
   localparam int unsigned CTRL_WDOG_IEN    = 5;
   localparam int unsigned CTRL_SINGLE_BIT  = 6;
   localparam int unsigned CTRL_REGULAR_BIT = 7;

   // values after reset
   localparam logic [STS_W-1:0]  STS_RESET  = 4'h0;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [STS_W-1:0]  MASK_RESET = 4'hF;

   // highest legal guarded channel
   localparam logic [CHAN_W-1:0] CHAN_MAX = 4'h9;

   // scan sequence tracking
   typedef enum logic [1:0] {
      SEQ_IDLE  = 2'b00,
      SEQ_RUN   = 2'b01,
      SEQ_ABORT = 2'b10
   } aswc_seq_e;

endpackage

// ### aswc_status_ctrl.sv
// Purpose: status flags, watchdog control and interrupt of the converter
// Assumes: converter core events are one-cycle pulses on CLK_IN
// Notes:   registers reached over a plain strobe port, read data one
//          cycle after the read strobe
//          flags set on the edge that takes the event and hold until
//          software writes a one; a set beats a clear in the same cycle
//          so an event that lands under a clear is never lost
//          window flag and abort pulse trail the conversion by two edges,
//          one more than the other flags, because the comparator registers its hit
//          the interrupt is registered from the stored flags, so it
//          trails a flag by one edge and a clear by one edge
//          the mask sits at its own offset with the status layout and
//          leaves reset letting every flag through
//          a selector above nine matches no channel, so software that
//          breaks the channel range loses its guard rather than
//          watching the wrong input
//          scan mode and both thresholds live in other registers and
//          arrive here as plain levels on this clock
//          busy follows the sequence state; it rises on the edge that takes
//          a start and drops on the group end or on an abort
//
// Notes on behaviour
// R1 - any_channel_done_flag sets on each finished regular conversion
// R2 - regular_started_flag sets when a regular conversion begins
// R3 - group_done_flag sets when the whole channel group has finished
// R4 - window_monitor_flag sets when a result leaves the threshold window
// R5 - the watchdog acts on regular channels only while its enable is one
// R6 - single-channel guard checks only the selected channel, else all
// R7 - a watchdog interrupt needs window_monitor_irq_enable set
// R8 - in scan mode a watchdog hit aborts the scan only with that enable
// R9 - the conversion-done interrupt needs group_done_irq_enable set
// R10 - a four-bit selector picks channel 0 to 9, other values unused
// R11 - with scan mode the group interrupt comes after the last channel
// R12 - the interrupt is the OR of each flag gated by its mask bit and its enable bit; start and any-done have no enable bit, only the mask gates them

`timescale 1ns/1ps

module aswc_status_ctrl (
   // clock and reset
   input  wire logic                              CLK_IN,
   input  wire logic                              SRST_IN,
   // register port
   input  wire logic [aswc_pkg::ADDR_W-1:0]       REG_ADDR_IN,
   input  wire logic [aswc_pkg::DATA_W-1:0]       REG_WDATA_IN,
   input  wire logic                              REG_WR_IN,
   input  wire logic                              REG_RD_IN,
   output      logic [aswc_pkg::DATA_W-1:0]       REG_RDATA_OUT,
   // converter core events
   input  wire logic                              CONV_START_IN,
   input  wire logic                              CONV_DONE_IN,
   input  wire logic [aswc_pkg::CHAN_W-1:0]       CONV_CHAN_IN,
   input  wire logic [aswc_pkg::RESULT_W-1:0]     CONV_RESULT_IN,
   input  wire logic                              CONV_SEQ_LAST_IN,
   // settings held outside this block
   input  wire logic                              SCAN_MODE_IN,
   input  wire logic [aswc_pkg::RESULT_W-1:0]     UPPER_THRESHOLD_IN,
   input  wire logic [aswc_pkg::RESULT_W-1:0]     LOWER_THRESHOLD_IN,
   // results
   output      logic                              IRQ_OUT,
   output      logic                              SCAN_ABORT_OUT,
   output      logic                              SEQ_BUSY_OUT
);

   // register state
   logic [aswc_pkg::STS_W-1:0]   status_reg;
   logic [aswc_pkg::STS_W-1:0]   status_next;
   logic [aswc_pkg::CTRL_W-1:0]  ctrl_reg;
   logic [aswc_pkg::STS_W-1:0]   mask_reg;
   logic [aswc_pkg::DATA_W-1:0]  rdata_reg;
   logic [aswc_pkg::DATA_W-1:0]  rdata_next;
   logic                         irq_reg;
   logic                         abort_reg;

   // sequence tracking
   aswc_pkg::aswc_seq_e          seq_state_reg;
   aswc_pkg::aswc_seq_e          seq_state_next;

   // decoded strobes and events
   logic                         wr_sts;
   logic                         wr_ctrl;
   logic                         wr_mask;
   logic [aswc_pkg::STS_W-1:0]   set_vec;
   logic [aswc_pkg::STS_W-1:0]   clr_vec;
   logic [aswc_pkg::STS_W-1:0]   enable_vec;
   logic                         group_end;
   logic                         wdog_hit;
   logic                         abort_cond;

   // control fields
   logic                         regular_en;
   logic                         single_en;
   logic                         wdog_ien;
   logic                         group_ien;
   logic [aswc_pkg::CHAN_W-1:0]  chan_sel;

   // bus-width register views and interrupt terms
   logic [aswc_pkg::DATA_W-1:0]  sts_word;
   logic [aswc_pkg::DATA_W-1:0]  ctrl_word;
   logic [aswc_pkg::DATA_W-1:0]  mask_word;
   logic [aswc_pkg::STS_W-1:0]   irq_term;

   // comparator carrier
   aswc_cmp_if cmp_bus ();

   // address match, used by both the write and the read paths
   // exact match on the whole byte address, no aliasing of offsets
   function automatic logic addr_is(
      input logic [aswc_pkg::ADDR_W-1:0] addr,
      input logic [aswc_pkg::ADDR_W-1:0] offset
   );
      addr_is = (addr == offset);
   endfunction

   // field views of the control register
   // named once here so the rest of the block never indexes ctrl_reg
   assign regular_en = ctrl_reg[aswc_pkg::CTRL_REGULAR_BIT];
   assign single_en  = ctrl_reg[aswc_pkg::CTRL_SINGLE_BIT];
   assign wdog_ien   = ctrl_reg[aswc_pkg::CTRL_WDOG_IEN];
   assign group_ien  = ctrl_reg[aswc_pkg::CTRL_GROUP_IEN];
   assign chan_sel   = ctrl_reg[aswc_pkg::CTRL_CHSEL_LSB +: aswc_pkg::CHAN_W];

   // present each finished conversion to the comparator
   // enable and guard travel with it, the comparator applies both
   assign cmp_bus.sample_valid = CONV_DONE_IN;
   assign cmp_bus.sample_chan  = CONV_CHAN_IN;
   assign cmp_bus.sample_value = CONV_RESULT_IN;
   assign cmp_bus.upper        = UPPER_THRESHOLD_IN;
   assign cmp_bus.lower        = LOWER_THRESHOLD_IN;
   assign cmp_bus.regular_en   = regular_en;                       // R5
   assign cmp_bus.single_en    = single_en;                        // R6
   assign cmp_bus.chan_sel     = chan_sel;                         // R10
   assign wdog_hit             = cmp_bus.hit;

   // window check lives in its own module
   // keeping the wide compares apart from the register logic
   aswc_window_cmp u_window_cmp (
      .clk_in  (CLK_IN),
      .srst_in (SRST_IN),
      .cmp_bus (cmp_bus)
   );

   // write decode; unmapped writes are dropped without a trace, and the
   // status offset only ever clears, a written zero leaves a flag alone
   always_comb begin
      wr_sts  = REG_WR_IN && addr_is(REG_ADDR_IN, aswc_pkg::STS_OFFSET);
      wr_ctrl = REG_WR_IN && addr_is(REG_ADDR_IN, aswc_pkg::CTRL_OFFSET);
      wr_mask = REG_WR_IN && addr_is(REG_ADDR_IN, aswc_pkg::MASK_OFFSET);
   end

   // control register; reserved upper bits are not stored, so they read
   // back as zero whatever software wrote there
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         ctrl_reg <= aswc_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= REG_WDATA_IN[aswc_pkg::CTRL_W-1:0];           // R10
      end
   end

   // interrupt mask, same layout as the status flags; a one lets the
   // flag reach the interrupt, a zero keeps it for polling only
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         mask_reg <= aswc_pkg::MASK_RESET;
      end else if (wr_mask) begin
         mask_reg <= REG_WDATA_IN[aswc_pkg::STS_W-1:0];
      end
   end

   // a group ends on its last channel in scan mode, else every conversion
   // is a group of one
   always_comb begin
      group_end = CONV_DONE_IN && (CONV_SEQ_LAST_IN || !SCAN_MODE_IN); // R11
   end

   // hardware set events for each flag; events need no synchroniser,
   // the converter core runs on this same clock
   always_comb begin
      set_vec                          = '0;
      set_vec[aswc_pkg::STS_ANY_BIT]   = CONV_DONE_IN;             // R1
      set_vec[aswc_pkg::STS_START_BIT] = CONV_START_IN;            // R2
      set_vec[aswc_pkg::STS_GROUP_BIT] = group_end;                // R3
      set_vec[aswc_pkg::STS_WDOG_BIT]  = wdog_hit;                 // R4
   end

   // write-one-to-clear from software; only the status offset clears,
   // so a stray write elsewhere never wipes an event
   always_comb begin
      clr_vec = wr_sts ? REG_WDATA_IN[aswc_pkg::STS_W-1:0] : '0;
   end

   // one sticky cell per flag; the set term is ORed in last so it wins
   // over a clear in the same cycle and no event is lost
   for (genvar b = 0; b < aswc_pkg::STS_W; b++) begin : g_flag
      assign status_next[b] = set_vec[b] || (status_reg[b] && !clr_vec[b]);
      // each flag's share of the interrupt, gated by mask and enable
      assign irq_term[b]    = status_reg[b] && mask_reg[b] && enable_vec[b];
   end

   // sticky status flags, one register for all four so a read always
   // sees a coherent snapshot
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         status_reg <= aswc_pkg::STS_RESET;
      end else begin
         status_reg <= status_next;                                // R1
      end
   end

   // abort only while a scan is really running; a hit that lands after
   // the group has closed finds the sequence idle and asks nothing
   always_comb begin
      abort_cond = wdog_hit && wdog_ien && SCAN_MODE_IN &&          // R8
                   (seq_state_reg == aswc_pkg::SEQ_RUN);
   end

   // sequence tracking: run from the first start to the group end
   //    idle:  no regular conversion under way
   //    run:   a conversion has started, its group has not ended
   //    abort: a watchdog hit cut the scan short; a start seen in this
   //           one cycle is ignored while the core drops the scan
   always_comb begin
      seq_state_next = seq_state_reg;
      case (seq_state_reg)
         aswc_pkg::SEQ_IDLE: begin
            if (CONV_START_IN) begin
               seq_state_next = aswc_pkg::SEQ_RUN;
            end
         end
         aswc_pkg::SEQ_RUN: begin
            if (abort_cond) begin
               seq_state_next = aswc_pkg::SEQ_ABORT;                // R8
            end else if (group_end) begin
               seq_state_next = aswc_pkg::SEQ_IDLE;
            end
         end
         aswc_pkg::SEQ_ABORT: begin
            // one cycle to let the core drop the scan
            seq_state_next = aswc_pkg::SEQ_IDLE;
         end
         default: begin
            // unused code, fall back to idle
            seq_state_next = aswc_pkg::SEQ_IDLE;
         end
      endcase
   end

   // sequence state register
   // reset returns to idle, dropping any half-finished scan
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         seq_state_reg <= aswc_pkg::SEQ_IDLE;
      end else begin
         seq_state_reg <= seq_state_next;
      end
   end

   // abort pulse to the converter core, one cycle long; the state
   // machine leaves run on the same edge, so it cannot repeat
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         abort_reg <= 1'b0;
      end else begin
         abort_reg <= abort_cond;                                  // R8
      end
   end

   // per-flag interrupt enables; start and any-done rely on the mask
   // alone, as the control word holds no enable of their own
   always_comb begin
      enable_vec                          = '1;
      enable_vec[aswc_pkg::STS_WDOG_BIT]  = wdog_ien;              // R7
      enable_vec[aswc_pkg::STS_GROUP_BIT] = group_ien;             // R9
   end

   // level interrupt from the already stored flags, so it rises one cycle
   // after the flag and falls one cycle after the clear
   // a registered output costs a cycle but keeps glitches off the pin
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |irq_term;                                     // R12
      end
   end

   // zero-extended views, so reserved bits never leak onto the bus
   always_comb begin
      sts_word                        = '0;
      sts_word[aswc_pkg::STS_W-1:0]   = status_reg;
      ctrl_word                       = '0;
      ctrl_word[aswc_pkg::CTRL_W-1:0] = ctrl_reg;
      mask_word                       = '0;
      mask_word[aswc_pkg::STS_W-1:0]  = mask_reg;
   end

   // read mux; unmapped addresses read as zero, and only a read strobe
   // opens the mux so the bus rests at zero between reads
   always_comb begin
      rdata_next = '0;
      if (REG_RD_IN) begin
         if (addr_is(REG_ADDR_IN, aswc_pkg::STS_OFFSET)) begin
            rdata_next = sts_word;
         end else if (addr_is(REG_ADDR_IN, aswc_pkg::CTRL_OFFSET)) begin
            rdata_next = ctrl_word;
         end else if (addr_is(REG_ADDR_IN, aswc_pkg::MASK_OFFSET)) begin
            rdata_next = mask_word;
         end else begin
            rdata_next = '0;
         end
      end
   end

   // read data stand for the one cycle after the strobe only
   // the zero default of the mux drops them on the next edge
   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // outputs straight from flip-flops
   // no logic between a register and a pin, so no glitches escape
   assign REG_RDATA_OUT  = rdata_reg;
   assign IRQ_OUT        = irq_reg;
   assign SCAN_ABORT_OUT = abort_reg;

   // busy view of the sequence, registered for a clean output
   // taken from the next state so busy lines up with the state register
   logic busy_reg;

   always_ff @(posedge CLK_IN) begin
      if (SRST_IN) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (seq_state_next == aswc_pkg::SEQ_RUN);
      end
   end

   assign SEQ_BUSY_OUT = busy_reg;

endmodule // aswc_status_ctrl

// ### aswc_window_cmp.sv
// Purpose: analog watchdog window check on each finished conversion
// Assumes: thresholds are stable while a result is presented
// Notes:   one cycle of latency from sample_valid to hit

`timescale 1ns/1ps

module aswc_window_cmp (
   // clock and reset
   input  wire logic   clk_in,
   input  wire logic   srst_in,
   // comparator carrier
   aswc_cmp_if.cmp     cmp_bus
);

   // true when a result lies outside [lower, upper]
   function automatic logic outside_window(
      input logic [aswc_pkg::RESULT_W-1:0] value,
      input logic [aswc_pkg::RESULT_W-1:0] hi,
      input logic [aswc_pkg::RESULT_W-1:0] lo
   );
      outside_window = (value > hi) || (value < lo);
   endfunction

   logic chan_guarded;

   // selector values above nine never equal a real channel, so they guard
   // nothing rather than aliasing onto one
   always_comb begin
      chan_guarded = !cmp_bus.single_en ||                        // R6
                     ((cmp_bus.sample_chan == cmp_bus.chan_sel) &&
                      (cmp_bus.chan_sel <= aswc_pkg::CHAN_MAX));  // R10
   end

   // registered hit pulse
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         cmp_bus.hit <= 1'b0;
      end else begin
         cmp_bus.hit <= cmp_bus.sample_valid &&
                        cmp_bus.regular_en &&                       // R5
                        chan_guarded &&
                        outside_window(cmp_bus.sample_value,
                                       cmp_bus.upper,
                                       cmp_bus.lower);              // R4
      end
   end

endmodule // aswc_window_cmp

// ### testbench.sv
// Purpose: self-checking bench for the converter status block
// Assumes: thresholds and scan mode driven here as plain levels
// Notes:   read results are compared from a queue of expected words
`timescale 1ns/1ps
module testbench;
   logic        CLK_IN, SRST_IN, REG_WR_IN, REG_RD_IN, rd_d;
   logic [7:0]  REG_ADDR_IN;
   logic [31:0] REG_WDATA_IN, REG_RDATA_OUT, c, exp_q[$];
   logic        CONV_START_IN, CONV_DONE_IN, CONV_SEQ_LAST_IN;
   logic        SCAN_MODE_IN, IRQ_OUT, SCAN_ABORT_OUT, SEQ_BUSY_OUT;
   logic [3:0]  CONV_CHAN_IN;
   logic [11:0] CONV_RESULT_IN, UPPER_THRESHOLD_IN, LOWER_THRESHOLD_IN;
   int          error_cnt, checked, ab_cnt, n, seed, i;
   // {ctrl, chan, result, 5'h0, scan, flag, abort}
   localparam logic [31:0] CASES [0:8] = '{32'h002FFF00, 32'h802FFF02,
      32'h80205002, 32'h80280000, 32'hC32FFF00, 32'hC99FFF02,
      32'hA02FFF02, 32'hA02FFF07, 32'h802FFF06};

   aswc_status_ctrl dut (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
      .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
      .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
      .REG_RDATA_OUT(REG_RDATA_OUT), .CONV_START_IN(CONV_START_IN),
      .CONV_DONE_IN(CONV_DONE_IN), .CONV_CHAN_IN(CONV_CHAN_IN),
      .CONV_RESULT_IN(CONV_RESULT_IN), .CONV_SEQ_LAST_IN(CONV_SEQ_LAST_IN),
      .SCAN_MODE_IN(SCAN_MODE_IN), .UPPER_THRESHOLD_IN(UPPER_THRESHOLD_IN),
      .LOWER_THRESHOLD_IN(LOWER_THRESHOLD_IN), .IRQ_OUT(IRQ_OUT),
      .SCAN_ABORT_OUT(SCAN_ABORT_OUT), .SEQ_BUSY_OUT(SEQ_BUSY_OUT));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("mismatches=%0d comparisons=%0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one-cycle register write, strobe dropped at the taking edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_IN);
      REG_WR_IN <= 1'b1;
      REG_ADDR_IN <= a;
      REG_WDATA_IN <= d;
      @(posedge CLK_IN);
      REG_WR_IN <= 1'b0;
   endtask

   // one-cycle read, expected word noted for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge CLK_IN);
      REG_RD_IN <= 1'b1;
      REG_ADDR_IN <= a;
      exp_q.push_back(e);
      @(posedge CLK_IN);
      REG_RD_IN <= 1'b0;
   endtask

   // converter core event pulse
   task automatic ev(input logic s, input logic d, input logic [3:0] ch,
                     input logic [11:0] r, input logic l);
      @(posedge CLK_IN);
      CONV_START_IN <= s;
      CONV_DONE_IN <= d;
      CONV_CHAN_IN <= ch;
      CONV_RESULT_IN <= r;
      CONV_SEQ_LAST_IN <= l;
      @(posedge CLK_IN);
      CONV_START_IN <= 1'b0;
      CONV_DONE_IN <= 1'b0;
   endtask

   // interrupt is registered one edge behind the flags
   task automatic irq_chk(input logic e);
      repeat (2) @(posedge CLK_IN);
      #1;
      chk({31'h0, IRQ_OUT}, {31'h0, e});
   endtask

   initial begin
      CLK_IN = 1'b0;
      forever #4 CLK_IN = ~CLK_IN;
   end

   // read data live only in the cycle after the strobe
   always @(posedge CLK_IN) rd_d <= REG_RD_IN;
   always @(negedge CLK_IN) if (rd_d) chk(REG_RDATA_OUT, exp_q.pop_front());
   // abort pulses counted as they appear
   always @(posedge CLK_IN) if (SCAN_ABORT_OUT === 1'b1) ab_cnt++;

   // hang guard, far beyond the planned run
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end

   initial begin
      {REG_WR_IN, REG_RD_IN, CONV_START_IN, CONV_DONE_IN} = '0;
      {CONV_SEQ_LAST_IN, SCAN_MODE_IN, rd_d} = '0;
      {REG_ADDR_IN, REG_WDATA_IN, CONV_CHAN_IN, CONV_RESULT_IN} = '0;
      UPPER_THRESHOLD_IN = 12'h800;
      LOWER_THRESHOLD_IN = 12'h100;
      seed = 66;
      SRST_IN = 1'b1;
      repeat (12) @(posedge CLK_IN);
      SRST_IN <= 1'b0;
      // reset values and an unmapped place
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h40, 32'hF);
      wr(8'h08, 32'hFFFFFFFF);
      rd(8'h08, 32'h0);
      // window cases: enable, single channel, bounds, abort
      for (i = 0; i < 9; i++) begin
         c = CASES[i];
         wr(8'h04, {24'hFFFFFF, c[31:24]});
         rd(8'h04, {24'h0, c[31:24]});
         wr(8'h40, 32'h1);
         wr(8'h00, 32'hF);
         SCAN_MODE_IN <= c[2];
         n = ab_cnt;
         if (c[2]) ev(1'b1, 1'b0, 4'h0, 12'h0, 1'b0);
         ev(1'b0, 1'b1, c[23:20], c[19:8], 1'b0);
         repeat (3) @(posedge CLK_IN);
         #1;
         chk({31'h0, IRQ_OUT}, {31'h0, c[1] & c[29]});
         chk(ab_cnt - n, {31'h0, c[0]});
         chk({31'h0, SEQ_BUSY_OUT}, {31'h0, c[2] & ~c[0]});
         rd(8'h00, {28'h0, 1'b1, c[2], ~c[2], c[1]});
      end
      // scan group: done only after the last channel
      wr(8'h40, 32'h2);
      wr(8'h04, 32'h0);
      wr(8'h00, 32'hF);
      ev(1'b0, 1'b1, 4'h1, 12'h200, 1'b0);
      rd(8'h00, 32'h8);
      ev(1'b0, 1'b1, 4'h1, 12'h200, 1'b1);
      rd(8'h00, 32'hA);
      irq_chk(1'b0);
      wr(8'h04, 32'h10);
      irq_chk(1'b1);
      wr(8'h40, 32'h0);
      irq_chk(1'b0);
      // start flag, single conversions, partial clear
      wr(8'h40, 32'hF);
      SCAN_MODE_IN <= 1'b0;
      wr(8'h00, 32'hF);
      ev(1'b1, 1'b0, 4'h0, 12'h0, 1'b0);
      rd(8'h00, 32'h4);
      ev(1'b0, 1'b1, 4'h5, 12'h300, 1'b0);
      rd(8'h00, 32'hE);
      wr(8'h00, 32'h4);
      rd(8'h00, 32'hA);
      // random in-window results never trip the watchdog
      wr(8'h04, 32'h80);
      wr(8'h00, 32'hF);
      repeat (8) ev(1'b0, 1'b1, 4'($unsigned($random(seed)) % 10),
                    12'h100 + 12'($unsigned($random(seed)) % 1793), 1'b0);
      rd(8'h00, 32'hA);
      // second reset in mid-run
      @(posedge CLK_IN);
      SRST_IN <= 1'b1;
      repeat (3) @(posedge CLK_IN);
      SRST_IN <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h40, 32'hF);
      irq_chk(1'b0);
      repeat (3) @(posedge CLK_IN);
      stop_test();
   end
endmodule // testbench

bind aswc_status_ctrl aswc_chk chk_i (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
   .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
   .REG_RDATA_OUT(REG_RDATA_OUT), .CONV_START_IN(CONV_START_IN),
   .CONV_DONE_IN(CONV_DONE_IN), .SCAN_MODE_IN(SCAN_MODE_IN),
   .IRQ_OUT(IRQ_OUT), .SCAN_ABORT_OUT(SCAN_ABORT_OUT),
   .SEQ_BUSY_OUT(SEQ_BUSY_OUT));
